//--- core/gspd_pkg.sv
// shared constants for the global sector protect decode block
package gspd_pkg;
  localparam int GSPD_NUM_SECTORS = 16;
  localparam int GSPD_BYTE_W = 8;
  localparam int GSPD_LOCK_BIT = 7;
  localparam int GSPD_GSEL_HI = 5;
  localparam int GSPD_GSEL_LO = 2;
  localparam int GSPD_GSEL_W = GSPD_GSEL_HI - GSPD_GSEL_LO + 1;
  localparam logic [3:0] GSPD_GSEL_ALL0 = 4'h0;
  localparam logic [3:0] GSPD_GSEL_ALL1 = 4'hF;
  localparam logic GSPD_LOCK_RST = 1'h0;
  localparam logic GSPD_SECT_RST = 1'h1;
  localparam logic [7:0] GSPD_OP_WRSR = 8'h01;
  localparam logic [7:0] GSPD_OP_PROT = 8'h36;
  localparam logic [7:0] GSPD_OP_UNPROT = 8'h39;
  localparam logic [7:0] GSPD_OP_WREN = 8'h06;
  localparam logic [7:0] GSPD_OP_WRDI = 8'h04;
  localparam logic [2:0] GSPD_SECT_IDX_LO = 3'h0;
  // whole bytes a frame must carry before its command is honoured
  localparam logic [5:0] GSPD_NB_OP = 6'h01;
  localparam logic [5:0] GSPD_NB_WRSR = 6'h02;
  localparam logic [5:0] GSPD_NB_SECT = 6'h04;
endpackage

//--- core/gspd_link.sv
// spi-side command capture; runs on the serial clock, hands a command word across by toggle
`timescale 1ns/1ps
`default_nettype none
module gspd_link
  import gspd_pkg::*;
(
  input wire logic i_sck,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic [GSPD_BYTE_W-1:0] o_opcode,
  output logic [GSPD_BYTE_W-1:0] o_data,
  output logic [5:0] o_bytes,
  output logic o_tgl
);
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [5:0] byte_cnt_q;
  logic [GSPD_BYTE_W-1:0] byte_w;

  assign byte_w = {shift_q, i_mosi};

  // the serial clock stands still between frames, so counters restart on chip select
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 6'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7 && byte_cnt_q != 6'h3F) begin
        byte_cnt_q <= byte_cnt_q + 6'h1;
      end
    end
  end

  always_ff @(posedge i_sck) begin
    shift_q <= byte_w[6:0];
  end

  always_ff @(posedge i_sck) begin
    if (bit_cnt_q == 3'h7) begin
      if (byte_cnt_q == 6'h0) begin
        o_opcode <= byte_w;
      end else if (byte_cnt_q == 6'h1) begin
        o_data <= byte_w;
      end
    end
  end

  // byte count is stable once cs rises; whole-byte check is done here, a partial last byte reports zero bytes
  // the toggle needs a known start, or the system side never sees an edge
  always_ff @(posedge i_cs_n or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bytes <= 6'h0;
      o_tgl <= 1'h0;
    end else begin
      o_bytes <= (bit_cnt_q == 3'h0) ? byte_cnt_q : 6'h0;
      o_tgl <= ~o_tgl;
    end
  end
endmodule // gspd_link
`default_nettype wire

//--- core/gspd_core.sv
// global protect and unprotect decode with lock bit, driven by status-register writes
`timescale 1ns/1ps
`default_nettype none
// Function
// - host writes ones to bits five to two to request protect-all
// - host writes zeros to bits five to two to request unprotect-all
// - global operations happen only as a side effect of status writes
// - status write also updates the protection lock bit
// - unlocked and pattern zero: clear all sectors, lock takes bit seven
// - unlocked and pattern ones: set all sectors, lock takes bit seven
// - other patterns leave sectors alone, lock still follows bit seven when unlocked
// - pin low with lock set: sectors hard-locked, global requests ignored
// - hard-locked: lock bit also refused; only pin high lets it clear
// - global and per-sector commands act on the same protection bits
// - pin high with lock set: globals blocked, bit seven zero clears lock
// - only bit seven stored; bits four to two read back pin and protection state
module gspd_core
  import gspd_pkg::*;
#(
  parameter int NUM_SECTORS = GSPD_NUM_SECTORS
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  output logic [NUM_SECTORS-1:0] o_sector_prot,
  output logic o_protection_lock_bit,
  output logic [GSPD_BYTE_W-1:0] o_status,
  output logic o_wel,
  output logic o_wrsr_done
);
  logic [GSPD_BYTE_W-1:0] lk_opcode;
  logic [GSPD_BYTE_W-1:0] lk_data;
  logic [5:0] lk_bytes;
  logic lk_tgl;

  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic [NUM_SECTORS-1:0] sect_q;
  logic lock_q;
  logic wel_q;
  logic [GSPD_BYTE_W-1:0] status_q;
  logic done_q;
  logic [NUM_SECTORS-1:0] sect_d;
  logic lock_d;

  localparam int SIDX_W = $clog2(NUM_SECTORS);

  logic cmd_evt;
  // command words held in this domain once the toggle has landed
  logic cmd_vld_q;
  logic [GSPD_BYTE_W-1:0] op_q;
  logic [GSPD_BYTE_W-1:0] dat_q;
  logic [5:0] nb_q;

  logic [GSPD_GSEL_W-1:0] gsel;
  logic wr_lock;
  logic hard_lock;
  logic soft_lock;
  logic is_wren;
  logic is_wrsr;
  logic is_sect;
  logic sect_set;
  logic glob_clr;
  logic glob_set;
  logic [SIDX_W-1:0] sect_idx;

  gspd_link u_link (
    .i_sck(i_sck),
    .i_nrst(i_nrst),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_opcode(lk_opcode),
    .o_data(lk_data),
    .o_bytes(lk_bytes),
    .o_tgl(lk_tgl)
  );

  // toggle crossing: link words are stable long before the toggle lands here
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tgl_s1_q <= 1'h0;
      tgl_s2_q <= 1'h0;
      tgl_s3_q <= 1'h0;
    end else begin
      tgl_s1_q <= lk_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_s1_q <= 1'h0;
      wp_s2_q <= 1'h0;
    end else begin
      wp_s1_q <= i_wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign cmd_evt = tgl_s2_q ^ tgl_s3_q;

  // the link words are read only here, one cycle after the toggle settled; the cost is a
  // cycle of latency, the gain is that no link-domain word feeds decode logic directly
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_vld_q <= 1'h0;
      op_q <= '0;
      dat_q <= '0;
      nb_q <= '0;
    end else begin
      cmd_vld_q <= cmd_evt;
      if (cmd_evt) begin
        op_q <= lk_opcode;
        dat_q <= lk_data;
        nb_q <= lk_bytes;
      end
    end
  end

  assign gsel = dat_q[GSPD_GSEL_HI:GSPD_GSEL_LO];
  assign wr_lock = dat_q[GSPD_LOCK_BIT];
  assign hard_lock = lock_q && !wp_s2_q;
  assign soft_lock = lock_q && wp_s2_q;
  assign is_wren = cmd_vld_q && op_q == GSPD_OP_WREN && nb_q >= GSPD_NB_OP;
  assign is_wrsr = cmd_vld_q && op_q == GSPD_OP_WRSR && nb_q >= GSPD_NB_WRSR && wel_q;
  assign is_sect = cmd_vld_q && nb_q >= GSPD_NB_SECT && wel_q && !lock_q
    && (op_q == GSPD_OP_PROT || op_q == GSPD_OP_UNPROT);
  assign sect_set = (op_q == GSPD_OP_PROT);
  assign glob_clr = is_wrsr && !lock_q && gsel == GSPD_GSEL_ALL0;
  assign glob_set = is_wrsr && !lock_q && gsel == GSPD_GSEL_ALL1;
  // sector index taken from the top address byte's low nibble (64 KB sectors)
  assign sect_idx = dat_q[SIDX_W-1:0];

  // one flop per sector; a global write reaches every sector on the same edge
  for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_sect
    assign sect_d[s] = glob_clr ? 1'h0
      : glob_set ? 1'h1
      : (is_sect && sect_idx == SIDX_W'(s)) ? sect_set
      : sect_q[s];

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        sect_q[s] <= GSPD_SECT_RST;
      end else begin
        sect_q[s] <= sect_d[s];
      end
    end
  end

  always_comb begin
    lock_d = lock_q;
    if (is_wrsr && !lock_q) begin
      lock_d = wr_lock;
    end else if (is_wrsr && soft_lock && !wr_lock) begin
      lock_d = 1'h0;
    end
    // hard-locked write leaves the lock untouched
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_q <= GSPD_LOCK_RST;
    end else begin
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wel_q <= 1'h0;
    end else if (cmd_vld_q) begin
      // any other command, even a refused one, drops the latch
      wel_q <= is_wren;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_q <= 1'h0;
    end else begin
      done_q <= is_wrsr;
    end
  end

  // status shows lock, pin and protection summary rather than written bits
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_q <= 8'h00;
    end else begin
      status_q <= {lock_d, 1'h0, 1'h0, wp_s2_q, |sect_d, |sect_d, wel_q, 1'h0};
      status_q[GSPD_GSEL_HI] <= 1'h0;
      status_q[GSPD_GSEL_LO+1] <= &sect_d;
    end
  end

  assign o_sector_prot = sect_q;
  assign o_protection_lock_bit = lock_q;
  assign o_status = status_q;
  assign o_wel = wel_q;
  assign o_wrsr_done = done_q;
endmodule // gspd_core
`default_nettype wire

//--- dv/gspd_host.sv
// serial host model that clocks whole frames into the protect decode core
`timescale 1ns/1ps
`default_nettype none
module gspd_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sck = 1'h0;
    o_cs_n = 1'h1;
    o_mosi = 1'h0;
  end
  // clock stands low between frames; msb leaves first
  task automatic frame(input logic [31:0] d, input int n);
    o_cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      o_mosi = d[31-i];
      #24 o_sck = 1'h1;
      #24 o_sck = 1'h0;
    end
    #24 o_cs_n = 1'h1;
    // data line has no pull, so a released line must not show the last bit
    o_mosi = ~o_mosi;
    #600;
  endtask
endmodule // gspd_host
`default_nettype wire

//--- dv/gspd_core_assertions.sv
// concurrent checks on the ports of the protect decode core
`timescale 1ns/1ps
`default_nettype none
module gspd_chk
  import gspd_pkg::*;
#(parameter int NUM_SECTORS = GSPD_NUM_SECTORS) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_wp_n,
  input wire logic [NUM_SECTORS-1:0] o_sector_prot,
  input wire logic o_protection_lock_bit,
  input wire logic [GSPD_BYTE_W-1:0] o_status,
  input wire logic o_wrsr_done
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // four cycles covers the pin synchroniser
  sequence s_hard;
    !i_wp_n [*4] ##0 o_protection_lock_bit;
  endsequence
  a_hard_keep_prot: assert property (s_hard |=> $stable(o_sector_prot))
    else $error("sectors changed while hard-locked");
  a_hard_keep_lock: assert property (s_hard |=> o_protection_lock_bit)
    else $error("lock cleared while hard-locked");
  a_lock_rise_done: assert property ($rose(o_protection_lock_bit) |-> o_wrsr_done)
    else $error("lock set without status write");
  a_clear_all_done: assert property (o_sector_prot == '0 && &$past(o_sector_prot)
    |-> o_wrsr_done)
    else $error("global clear without status write");
  a_set_all_done: assert property (&o_sector_prot && $past(o_sector_prot) == '0
    |-> o_wrsr_done)
    else $error("global set without status write");
  a_done_one_cycle: assert property (o_wrsr_done |=> !o_wrsr_done)
    else $error("done pulse too long");
  a_done_prot_still: assert property (o_wrsr_done |=> $stable(o_sector_prot))
    else $error("sectors not updated in one step");
  a_status_lock: assert property ($changed(o_protection_lock_bit)
    |-> ##[0:1] o_status[7] == o_protection_lock_bit)
    else $error("status bit seven not the lock");
endmodule // gspd_chk
bind gspd_core gspd_chk #(.NUM_SECTORS(NUM_SECTORS)) gspd_chk_inst (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wp_n(i_wp_n),
  .o_sector_prot(o_sector_prot), .o_protection_lock_bit(o_protection_lock_bit),
  .o_status(o_status), .o_wrsr_done(o_wrsr_done));
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the global protect decode core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gspd_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic wp_n = 1'h1;
  wire sck;
  wire cs_n;
  wire mosi;
  logic [GSPD_NUM_SECTORS-1:0] prot;
  logic lock;
  logic [GSPD_BYTE_W-1:0] stat;
  logic wel;
  logic done;
  int done_cnt = 0;
  int num_errors = 0;
  int cmp_count = 0;
  gspd_host gspd_host_inst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
  gspd_core gspd_core_inst (.i_sys_clk(clk), .i_nrst(nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_wp_n(wp_n), .o_sector_prot(prot), .o_protection_lock_bit(lock),
    .o_status(stat), .o_wel(wel), .o_wrsr_done(done));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    if (done === 1'h1) begin
      done_cnt++;
    end
  end
  task automatic wr(input logic [7:0] d);
    int n0;
    gspd_host_inst.frame({GSPD_OP_WREN, 24'h000000}, 8);
    chk_bit(wel, 1'h1);
    n0 = done_cnt;
    gspd_host_inst.frame({GSPD_OP_WRSR, d, 16'h0000}, 16);
    chk_bit(wel, 1'h0);
    chk_bit(done_cnt - n0 == 1, 1'h1);
  endtask
  task automatic chk_bit(input logic a, input logic e);
    cmp_count++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch t=%0t bit=%b exp=%b", $time, a, e);
    end
  endtask
  task automatic chk_stat(input logic [7:0] e);
    cmp_count++;
    if (stat !== e) begin
      num_errors++;
      $display("mismatch t=%0t status=%h exp=%h", $time, stat, e);
    end
  endtask
  task automatic chk(input logic [GSPD_NUM_SECTORS-1:0] ep, input logic el);
    cmp_count++;
    if ({prot, lock} !== {ep, el}) begin
      num_errors++;
      $display("mismatch t=%0t prot=%h lock=%b", $time, prot, lock);
    end
    chk_stat({el, 2'h0, wp_n, &ep, |ep, 2'h0});
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    #2 wp_n = v;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_unlocked();
    wr(8'h00);
    chk(16'h0000, 1'h0);
    wr(8'h7F);
    chk(16'hFFFF, 1'h0);
    gspd_host_inst.frame({GSPD_OP_WREN, 24'h000000}, 8);
    gspd_host_inst.frame({GSPD_OP_UNPROT, 8'h03, 16'h0000}, 32);
    chk(16'hFFF7, 1'h0);
    wr(8'h3B);
    chk(16'hFFF7, 1'h0);
    wr(8'h84);
    chk(16'hFFF7, 1'h1);
  endtask
  task automatic t_soft();
    wr(8'h3C);
    chk(16'hFFF7, 1'h0);
    wr(8'h80);
    chk(16'h0000, 1'h1);
  endtask
  task automatic t_hard();
    pin(1'h0);
    wr(8'h3C);
    chk(16'h0000, 1'h1);
    pin(1'h1);
    wr(8'h3C);
    chk(16'h0000, 1'h0);
    wr(8'h3C);
    chk(16'hFFFF, 1'h0);
  endtask
  task automatic end_sim();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #2 nrst = 1'h1;
    // wait out the pin synchroniser before looking at the status word
    repeat (4) @(posedge clk);
    #2 chk(16'hFFFF, 1'h0);
    t_unlocked();
    t_soft();
    t_hard();
    end_sim();
  end
  // the whole run needs about 26 us
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
